//--- hw/eivt_pkg.sv
// constants, register map and carrier types of the external interrupt and vector block
// assumes a single 50 MHz clock and an APB slave port with 32-bit data
`default_nettype none

package eivt_pkg;

    localparam int NUM_PC_PINS   = 12;
    localparam int GRP_A_W       = 8;
    localparam int GRP_B_W       = 4;
    localparam int NUM_PERIPH    = 13;
    localparam int NUM_RESET_SRC = 4;
    localparam int NUM_REQ       = 3 + NUM_PERIPH;
    localparam int ADDR_W        = 8;

    // program addresses of the vector table
    localparam logic [15:0] VEC_RESET            = 16'h0000;
    localparam logic [15:0] VEC_EXT_IRQ          = 16'h0001;
    localparam logic [15:0] VEC_GRP_A            = 16'h0002;
    localparam logic [15:0] VEC_GRP_B            = 16'h0003;
    localparam logic [15:0] VEC_WATCHDOG         = 16'h0004;
    localparam logic [15:0] VEC_WIDE_CAPTURE     = 16'h0005;
    localparam logic [15:0] VEC_WIDE_MATCH_A     = 16'h0006;
    localparam logic [15:0] VEC_WIDE_MATCH_B     = 16'h0007;
    localparam logic [15:0] VEC_WIDE_OVERFLOW    = 16'h0008;
    localparam logic [15:0] VEC_NARROW_MATCH_A   = 16'h0009;
    localparam logic [15:0] VEC_NARROW_MATCH_B   = 16'h000A;
    localparam logic [15:0] VEC_NARROW_OVERFLOW  = 16'h000B;
    localparam logic [15:0] VEC_COMPARATOR       = 16'h000C;
    localparam logic [15:0] VEC_CONVERTER_DONE   = 16'h000D;
    localparam logic [15:0] VEC_NVDATA_READY     = 16'h000E;
    localparam logic [15:0] VEC_SERIAL_START     = 16'h000F;
    localparam logic [15:0] VEC_SERIAL_OVERFLOW  = 16'h0010;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK_A = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MASK_B = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FLAGS  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_SRC_EN = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

    // status field positions
    localparam int STAT_REQ_BIT = 16;
    localparam int STAT_PIN_BIT = 17;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } eivt_sense_e;

    typedef struct packed {
        logic        globalEn;
        logic        grpBEnable;
        logic        grpAEnable;
        logic        extEnable;
        eivt_sense_e senseSelect;
    } eivt_ctrl_s;

    typedef struct packed {
        logic grpBFlag;
        logic grpAFlag;
        logic extFlag;
    } eivt_flags_s;

    localparam int CTRL_W  = $bits(eivt_ctrl_s);
    localparam int FLAGS_W = $bits(eivt_flags_s);

    localparam eivt_ctrl_s            CTRL_RST   = '{1'b0, 1'b0, 1'b0, 1'b0, SENSE_LOW};
    localparam eivt_flags_s           FLAGS_RST  = '{1'b0, 1'b0, 1'b0};
    localparam logic [GRP_A_W-1:0]    MASK_A_RST = 8'h00;
    localparam logic [GRP_B_W-1:0]    MASK_B_RST = 4'h0;
    localparam logic [NUM_PERIPH-1:0] SRC_EN_RST = 13'h0000;

endpackage : eivt_pkg

`default_nettype wire

//--- hw/eivt_sync2.sv
// two-stage synchroniser for asynchronous pin levels
// assumes the inputs may change at any time relative to clk
`default_nettype none

module eivt_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage1_ff <= '0;
            syncOut   <= '0;
        end else begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end

endmodule : eivt_sync2

`default_nettype wire

//--- hw/eivt_top.sv
// external interrupt detection and vector table selection, with APB registers
// assumes pins are asynchronous, peripheral requests come from logic on clk
// What this block does
// - every reset cause fetches address zero
// - external pin vector 0x0001, group A 0x0002
// - group B 0x0003, watchdog 0x0004
// - wide timer at 0x0005 to 0x0008
// - narrow timer at 0x0009 to 0x000B
// - remaining sources at 0x000C to 0x0010
// - disabled sources never cause a fetch
// - pins trigger even when driven as outputs
// - group A requests on enabled pin toggle
// - group B requests on enabled pin toggle
// - per-pin mask gates group contribution
// - pin changes wake without a clock
// - falling, rising or low level on external pin
// - low level requests while pin stays low
// - edges recognised only with running clock
// - low level wakes without a clock
// - level gone before wake: no interrupt
// - sense codes: low, any, falling, rising
// - pulses over one clock period register
// - flags set by event, cleared by vector/write
// - group forwards only with both enables set
//
// The register offsets and the APB slave port were decided locally.
`default_nettype none

module eivt_top
    import eivt_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     extIrqPin,
    input  wire logic [NUM_PC_PINS-1:0]   pinChangePins,
    input  wire logic [NUM_RESET_SRC-1:0] resetCauses,
    input  wire logic [NUM_PERIPH-1:0]    periphReq,
    input  wire logic                     irqAck,
    output logic                          irqReq,
    output logic      [15:0]              irqVecAddr,
    output logic                          coreRestart,
    output logic                          wakeReq
);

    // vector addresses of every request, lowest index wins
    // external, group, watchdog and remaining peripheral vectors
    localparam logic [15:0] REQ_VEC [NUM_REQ] = '{
        VEC_EXT_IRQ, VEC_GRP_A, VEC_GRP_B, VEC_WATCHDOG,
        VEC_WIDE_CAPTURE, VEC_WIDE_MATCH_A, VEC_WIDE_MATCH_B, VEC_WIDE_OVERFLOW,
        VEC_NARROW_MATCH_A, VEC_NARROW_MATCH_B, VEC_NARROW_OVERFLOW,
        VEC_COMPARATOR, VEC_CONVERTER_DONE, VEC_NVDATA_READY,
        VEC_SERIAL_START, VEC_SERIAL_OVERFLOW
    };

    localparam int SYNC_W = 1 + NUM_PC_PINS + NUM_RESET_SRC;

    eivt_ctrl_s                 ctrl_ff;
    eivt_flags_s                flags_ff;
    logic [GRP_A_W-1:0]         maskA_ff;
    logic [GRP_B_W-1:0]         maskB_ff;
    logic [NUM_PERIPH-1:0]      srcEn_ff;
    logic [31:0]                prdata_ff;
    logic                       irqReq_ff;
    logic [15:0]                irqVecAddr_ff;
    logic                       coreRestart_ff;
    logic                       extPrev_ff;
    logic [NUM_PC_PINS-1:0]     pcPrev_ff;
    logic                       resetPrev_ff;

    logic [SYNC_W-1:0]          syncBus;
    logic                       extSync;
    logic [NUM_PC_PINS-1:0]     pcSync;
    logic [NUM_RESET_SRC-1:0]   resetSync;
    logic [NUM_PC_PINS-1:0]     pcMask;
    logic [NUM_PC_PINS-1:0]     pcIn;
    logic                       grpASetFlag;
    logic                       grpBSetFlag;
    logic                       extEdge;
    logic                       levelMode;
    logic                       resetAny;
    logic                       setupPhase;
    logic                       accessPhase;
    logic                       addrOk;
    logic                       wrEn;
    logic [NUM_REQ-1:0]         pending;
    logic                       nxt_irqReq;
    logic [15:0]                nxt_irqVecAddr;
    logic [31:0]                nxt_prdata;
    logic                       ackExt;
    logic                       ackGrpA;
    logic                       ackGrpB;

    // merge write data into a register image according to byte strobes
    function automatic logic [31:0] strbMerge(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = newVal[8*b +: 8];
            end
        end
        return res;
    endfunction : strbMerge

    // ---------------- pin sampling ----------------
    // pad level sampled whatever the pin direction
    eivt_sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .asyncIn ({resetCauses, pinChangePins, extIrqPin}),
        .syncOut (syncBus)
    );

    assign extSync   = syncBus[0];
    assign pcSync    = syncBus[NUM_PC_PINS:1];
    assign resetSync = syncBus[SYNC_W-1 -: NUM_RESET_SRC];
    assign resetAny  = |resetSync;

    // ---------------- pin change detection ----------------
    // per-pin mask ahead of comparison
    assign pcMask = {maskB_ff, maskA_ff};
    assign pcIn   = pcSync & pcMask;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pcPrev_ff <= '0;
        end else begin
            pcPrev_ff <= pcIn;
        end
    end

    // any enabled pin of 7..0 toggles
    assign grpASetFlag = |(pcIn[GRP_A_W-1:0] ^ pcPrev_ff[GRP_A_W-1:0]);
    // any enabled pin of 11..8 toggles
    assign grpBSetFlag = |(pcIn[NUM_PC_PINS-1:GRP_A_W] ^ pcPrev_ff[NUM_PC_PINS-1:GRP_A_W]);

    // ---------------- external pin sense ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            extPrev_ff <= 1'b1;
        end else begin
            extPrev_ff <= extSync;
        end
    end

    assign levelMode = (ctrl_ff.senseSelect == SENSE_LOW);

    // edges seen on clocked samples only
    // one-period pulse reaches the second stage
    always_comb begin
        case (ctrl_ff.senseSelect)
            SENSE_ANY:  extEdge = extSync ^ extPrev_ff;
            SENSE_FALL: extEdge = extPrev_ff & ~extSync;
            SENSE_RISE: extEdge = ~extPrev_ff & extSync;
            default:    extEdge = 1'b0;
        endcase
    end

    // ---------------- clockless wake path ----------------
    // raw low level wakes without clock
    assign wakeReq = (ctrl_ff.extEnable & levelMode & ~extIrqPin)
                   | (ctrl_ff.grpAEnable
                      & (|((pinChangePins[GRP_A_W-1:0] & maskA_ff)
                           ^ pcPrev_ff[GRP_A_W-1:0])))
                   | (ctrl_ff.grpBEnable
                      & (|((pinChangePins[NUM_PC_PINS-1:GRP_A_W] & maskB_ff)
                           ^ pcPrev_ff[NUM_PC_PINS-1:GRP_A_W])));

    // ---------------- APB slave ----------------
    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign pready      = 1'b1;

    always_comb begin
        case (paddr)
            REG_CTRL, REG_MASK_A, REG_MASK_B,
            REG_FLAGS, REG_SRC_EN, REG_STATUS: addrOk = 1'b1;
            default:                           addrOk = 1'b0;
        endcase
    end

    assign pslverr = accessPhase & ~addrOk;
    assign wrEn    = accessPhase & pwrite & addrOk;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wrEn && paddr == REG_CTRL) begin
            ctrl_ff <= eivt_ctrl_s'(strbMerge({{(32-CTRL_W){1'b0}}, ctrl_ff},
                                              pwdata, pstrb));
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            maskA_ff <= MASK_A_RST;
            maskB_ff <= MASK_B_RST;
        end else if (wrEn && paddr == REG_MASK_A) begin
            maskA_ff <= pstrb[0] ? pwdata[GRP_A_W-1:0] : maskA_ff;
        end else if (wrEn && paddr == REG_MASK_B) begin
            maskB_ff <= pstrb[0] ? pwdata[GRP_B_W-1:0] : maskB_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            srcEn_ff <= SRC_EN_RST;
        end else if (wrEn && paddr == REG_SRC_EN) begin
            srcEn_ff <= NUM_PERIPH'(strbMerge({{(32-NUM_PERIPH){1'b0}}, srcEn_ff},
                                              pwdata, pstrb));
        end
    end

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            REG_CTRL:   nxt_prdata[CTRL_W-1:0]     = ctrl_ff;
            REG_MASK_A: nxt_prdata[GRP_A_W-1:0]    = maskA_ff;
            REG_MASK_B: nxt_prdata[GRP_B_W-1:0]    = maskB_ff;
            REG_FLAGS:  nxt_prdata[FLAGS_W-1:0]    = flags_ff;
            REG_SRC_EN: nxt_prdata[NUM_PERIPH-1:0] = srcEn_ff;
            REG_STATUS: begin
                nxt_prdata[15:0]         = irqVecAddr_ff;
                nxt_prdata[STAT_REQ_BIT] = irqReq_ff;
                nxt_prdata[STAT_PIN_BIT] = extSync;
            end
            default:    nxt_prdata = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle, presented in the access cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

    // ---------------- flags ----------------
    assign ackExt  = irqAck & irqReq_ff & (irqVecAddr_ff == VEC_EXT_IRQ);
    assign ackGrpA = irqAck & irqReq_ff & (irqVecAddr_ff == VEC_GRP_A);
    assign ackGrpB = irqAck & irqReq_ff & (irqVecAddr_ff == VEC_GRP_B);

    // set by event wins over vector or write-one clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags_ff <= FLAGS_RST;
        end else begin
            if (levelMode) begin
                flags_ff.extFlag <= 1'b0;
            end else if (extEdge) begin
                flags_ff.extFlag <= 1'b1;
            end else if (ackExt || (wrEn && paddr == REG_FLAGS && pstrb[0] && pwdata[0])) begin
                flags_ff.extFlag <= 1'b0;
            end
            if (grpASetFlag) begin
                flags_ff.grpAFlag <= 1'b1;
            end else if (ackGrpA || (wrEn && paddr == REG_FLAGS && pstrb[0] && pwdata[1])) begin
                flags_ff.grpAFlag <= 1'b0;
            end
            if (grpBSetFlag) begin
                flags_ff.grpBFlag <= 1'b1;
            end else if (ackGrpB || (wrEn && paddr == REG_FLAGS && pstrb[0] && pwdata[2])) begin
                flags_ff.grpBFlag <= 1'b0;
            end
        end
    end

    // ---------------- request gating ----------------
    // level or edge flag selects the source
    // level request holds while pin low
    // level gone before sampling gives nothing
    assign pending[0] = ctrl_ff.globalEn & ctrl_ff.extEnable
                      & (levelMode ? ~extSync : flags_ff.extFlag);
    // group and global enable both needed
    assign pending[1] = ctrl_ff.globalEn & ctrl_ff.grpAEnable & flags_ff.grpAFlag;
    assign pending[2] = ctrl_ff.globalEn & ctrl_ff.grpBEnable & flags_ff.grpBFlag;

    // peripheral requests gated by their enables
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
            assign pending[3+gi] = ctrl_ff.globalEn & srcEn_ff[gi] & periphReq[gi];
        end
    endgenerate

    // lowest vector address has highest priority
    always_comb begin
        nxt_irqReq     = 1'b0;
        nxt_irqVecAddr = VEC_RESET;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (pending[i]) begin
                nxt_irqReq     = 1'b1;
                nxt_irqVecAddr = REQ_VEC[i];
            end
        end
    end

    // ---------------- vector output ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            resetPrev_ff <= 1'b0;
        end else begin
            resetPrev_ff <= resetAny;
        end
    end

    // any reset cause forces address zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irqReq_ff      <= 1'b0;
            irqVecAddr_ff  <= VEC_RESET;
            coreRestart_ff <= 1'b0;
        end else if (resetAny) begin
            irqReq_ff      <= 1'b0;
            irqVecAddr_ff  <= VEC_RESET;
            coreRestart_ff <= ~resetPrev_ff;
        end else begin
            irqReq_ff      <= nxt_irqReq & ~irqAck;
            irqVecAddr_ff  <= nxt_irqVecAddr;
            coreRestart_ff <= 1'b0;
        end
    end

    assign irqReq      = irqReq_ff;
    assign irqVecAddr  = irqVecAddr_ff;
    assign coreRestart = coreRestart_ff;

endmodule : eivt_top

`default_nettype wire

//--- tb/eivt_core_model.sv
// core model: takes the presented vector and acknowledges it
// assumes irqReq and irqVecAddr are registered levels on clk
`default_nettype none

module eivt_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVecAddr,
    input  wire logic        ackEn,
    input  wire logic [3:0]  ackDelay,
    output logic             irqAck,
    output logic      [15:0] lastVec
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] waitCnt_ff;

    always_ff @(posedge clk) begin
        if (!rstn || !irqReq || !ackEn || irqAck) begin
            waitCnt_ff <= 4'h0;
            irqAck     <= 1'b0;
        end else if (waitCnt_ff == ackDelay) begin
            irqAck <= 1'b1;
        end else begin
            waitCnt_ff <= waitCnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lastVec <= 16'h0000;
        end else if (irqReq && ackEn && !irqAck && waitCnt_ff == ackDelay) begin
            lastVec <= irqVecAddr;
        end
    end
endmodule : eivt_core_model

`default_nettype wire

//--- tb/eivt_assertions.sv
// port checks on the vector block
// assumes one clock domain and a bind onto eivt_top
`default_nettype none

module eivt_checker
    import eivt_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic [NUM_RESET_SRC-1:0] resetCauses,
    input wire logic                     irqAck,
    input wire logic                     irqReq,
    input wire logic [15:0]              irqVecAddr,
    input wire logic                     coreRestart
);
    timeunit 1ns;
    timeprecision 1ps;

    logic anyReset;
    assign anyReset = |resetCauses;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_causeHeld;
        anyReset [*5];
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    a_reset_vector: assert property (
        s_causeHeld |-> !irqReq && irqVecAddr == VEC_RESET)
        else $error("reset cause left a vector request");
    a_restart_pulse: assert property (coreRestart |=> !coreRestart)
        else $error("restart pulse longer than one cycle");
    a_restart_cause: assert property (
        coreRestart |-> $past(anyReset, 1) || $past(anyReset, 2) || $past(anyReset, 3))
        else $error("restart without a reset cause");
    a_vector_range: assert property (
        irqReq |-> irqVecAddr inside {[16'h0001:16'h0010]})
        else $error("request outside the vector table");
    a_ack_retires: assert property (irqReq && irqAck |=> !irqReq)
        else $error("request held after acknowledge");
    a_error_phase: assert property (pslverr |-> s_access)
        else $error("slave error outside access phase");
    a_unmapped_zero: assert property (s_access ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_zero_wait: assert property (s_access |-> pready)
        else $error("access phase without ready");
endmodule : eivt_checker

bind eivt_top eivt_checker u_checker (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetCauses(resetCauses),
    .irqAck(irqAck), .irqReq(irqReq), .irqVecAddr(irqVecAddr), .coreRestart(coreRestart)
);

`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the interrupt detection and vector block
// assumes APB zero-wait slave; core model acks only while ackEn is high
`default_nettype none

module tb_top
    import eivt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk = 1'b0;
    logic                     rstn = 1'b0;
    logic [ADDR_W-1:0]        paddr = '0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [31:0]              pwdata = '0;
    logic [3:0]               pstrb = 4'hF;
    logic                     extIrqPin = 1'b1;
    logic [NUM_PC_PINS-1:0]   pcPins = '0;
    logic [NUM_RESET_SRC-1:0] resetCauses = '0;
    logic [NUM_PERIPH-1:0]    periphReq = '0;
    logic                     ackEn = 1'b0;
    logic [3:0]               ackDelay = 4'h0;
    logic [31:0]              prdata, rd;
    logic                     pready, pslverr, err, irqAck, irqReq, coreRestart, wakeReq;
    logic [15:0]              irqVecAddr, lastVec;
    int                       n_errors = 0;
    int                       n_checks = 0;

    always #10 clk = ~clk;

    eivt_top dut (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIrqPin(extIrqPin),
        .pinChangePins(pcPins), .resetCauses(resetCauses), .periphReq(periphReq),
        .irqAck(irqAck), .irqReq(irqReq), .irqVecAddr(irqVecAddr),
        .coreRestart(coreRestart), .wakeReq(wakeReq)
    );
    eivt_core_model core (
        .clk(clk), .rstn(rstn), .irqReq(irqReq), .irqVecAddr(irqVecAddr), .ackEn(ackEn),
        .ackDelay(ackDelay), .irqAck(irqAck), .lastVec(lastVec)
    );

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdChk

    task automatic waitHigh(ref logic s);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (s !== 1'b1 && k < 40);
        if (s !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask : waitHigh

    task automatic expVec(input logic [15:0] v);
        repeat (2) @(posedge clk);
        waitHigh(irqReq);
        chk(32'(irqVecAddr), 32'(v));
    endtask : expVec

    // no request may show during the window
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (3) @(posedge clk);
        repeat (12) begin
            @(negedge clk);
            seen = seen | (irqReq !== 1'b0);
        end
        chk(32'(seen), 32'h0000_0000);
    endtask : quiet

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 5; a++) rdChk(ADDR_W'(4 * a), 32'h0000_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        chk(32'(err), 32'h0000_0001);
        rdChk(8'h18, 32'h0000_0000);
        wr(REG_MASK_B, 32'hFFFF_FFFF);
        rdChk(REG_MASK_B, 32'h0000_000F);
        wr(REG_MASK_B, 32'h0000_0008);
        wr(REG_CTRL, 32'h0000_0020);
        for (int i = 0; i < NUM_PERIPH; i++) begin
            wr(REG_SRC_EN, 32'h0000_0000);
            @(posedge clk);
            periphReq <= 13'h0001 << i;
            quiet();
            wr(REG_SRC_EN, 32'h0000_0001 << i);
            expVec(VEC_WATCHDOG + 16'(i));
            @(posedge clk);
            periphReq <= '0;
        end
        wr(REG_SRC_EN, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0028);
        wr(REG_MASK_A, 32'h0000_0001);
        @(posedge clk);
        pcPins[1] <= 1'b1;
        quiet();
        @(posedge clk);
        pcPins[0] <= 1'b1;
        #1 chk(32'(wakeReq), 32'h0000_0001);
        expVec(VEC_GRP_A);
        rdChk(REG_FLAGS, 32'h0000_0002);
        wr(REG_FLAGS, 32'h0000_0002);
        quiet();
        wr(REG_CTRL, 32'h0000_0008);
        @(posedge clk);
        pcPins[0] <= 1'b0;
        quiet();
        wr(REG_CTRL, 32'h0000_0028);
        expVec(VEC_GRP_A);
        ackEn <= 1'b1;
        waitHigh(irqAck);
        chk(32'(lastVec), 32'(VEC_GRP_A));
        quiet();
        ackEn <= 1'b0;
        wr(REG_CTRL, 32'h0000_0038);
        @(posedge clk);
        pcPins[11] <= 1'b1;
        pcPins[0]  <= 1'b1;
        expVec(VEC_GRP_A);
        wr(REG_FLAGS, 32'h0000_0002);
        expVec(VEC_GRP_B);
        ackDelay <= 4'h3;
        ackEn    <= 1'b1;
        waitHigh(irqAck);
        chk(32'(lastVec), 32'(VEC_GRP_B));
        quiet();
        ackEn <= 1'b0;
        for (int m = 1; m < 4; m++) begin
            @(posedge clk);
            extIrqPin <= (m != 3);
            wr(REG_CTRL, 32'h0000_0020 | 32'(m));
            wr(REG_FLAGS, 32'h0000_0001);
            wr(REG_CTRL, 32'h0000_0024 | 32'(m));
            @(posedge clk);
            extIrqPin <= ~extIrqPin;
            repeat (2) @(posedge clk);
            extIrqPin <= ~extIrqPin;
            expVec(VEC_EXT_IRQ);
            wr(REG_FLAGS, 32'h0000_0001);
            quiet();
        end
        @(posedge clk);
        extIrqPin <= 1'b1;
        wr(REG_CTRL, 32'h0000_0024);
        @(posedge clk);
        extIrqPin <= 1'b0;
        #1 chk(32'(wakeReq), 32'h0000_0001);
        expVec(VEC_EXT_IRQ);
        // source holds the level well past wake-up
        repeat (20) @(negedge clk);
        chk(32'(irqReq), 32'h0000_0001);
        rdChk(REG_FLAGS, 32'h0000_0000);
        @(posedge clk);
        extIrqPin <= 1'b1;
        quiet();
        wr(REG_CTRL, 32'h0000_0020);
        wr(REG_SRC_EN, 32'h0000_0001);
        @(posedge clk);
        periphReq <= 13'h0001;
        expVec(VEC_WATCHDOG);
        rdChk(REG_STATUS, 32'h0003_0004);
        for (int i = 0; i < NUM_RESET_SRC; i++) begin
            @(posedge clk);
            resetCauses <= 4'h1 << i;
            waitHigh(coreRestart);
            repeat (4) @(negedge clk);
            chk(32'({irqReq, irqVecAddr}), 32'h0000_0000);
            @(posedge clk);
            resetCauses <= '0;
            expVec(VEC_WATCHDOG);
        end
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
